// ---- rtl/rad_pkg.sv ----
// Constants, register map and types of the antenna diversity and channel assessment block.
package rad_pkg;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ        = 250;
    localparam int SEARCH_CYC_DEF = 4000;
    localparam int TMR_W          = 22;
    localparam int PAIRS          = 10;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [9:0] A_CFG0 = 10'h103;
    localparam logic [9:0] A_THR  = 10'h105;
    localparam logic [9:0] A_DIV  = 10'h129;
    localparam logic [9:0] A_STR0 = 10'h12b;
    localparam logic [9:0] A_STR1 = 10'h12c;
    localparam logic [9:0] A_TEST = 10'h139;
    localparam logic [9:0] A_STAT = 10'h140;
    localparam logic [9:0] A_CMD  = 10'h141;

    localparam int B_FRZ    = 0;
    localparam int B_MANTX  = 4;
    localparam int B_PER_LO = 1;
    localparam int B_DIVEN  = 0;
    localparam int B_ANT    = 1;
    localparam int B_LVL    = 3;
    localparam int B_PAT0   = 6;
    localparam int B_PAT1   = 4;
    localparam int B_CONT   = 0;
    localparam int B_C_RX   = 0;
    localparam int B_C_GO   = 1;
    localparam int B_C_ON   = 2;
    localparam logic [2:0] PER_INF = 3'h7;
    localparam logic [7:0] RST8    = 8'h00;

    typedef enum logic [2:0] {
        ST_ON,
        ST_SRCH,
        ST_PKT,
        ST_RCV,
        ST_TX
    } rad_state_t;

    // Evaluation period in microseconds for each field code.
    function automatic int period_us(input logic [2:0] code);
        case (code)
            3'h0:    period_us = 160;
            3'h1:    period_us = 320;
            3'h2:    period_us = 640;
            3'h3:    period_us = 1280;
            3'h4:    period_us = 1920;
            3'h5:    period_us = 2560;
            default: period_us = 9960;
        endcase
    endfunction

endpackage

// ---- rtl/rad_preamble_corr.sv ----
// Preamble qualifier: counts consecutive alternating received bits.
`timescale 1ns/1ps
`default_nettype none
module rad_preamble_corr #(
    parameter int PAIRS = rad_pkg::PAIRS
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic clr,
    input  wire logic bit_vld,
    input  wire logic bit_in,
    output logic      found
);
    localparam int NEED = 2 * PAIRS - 1;
    logic [5:0] run_ff;
    logic       last_ff;
    logic       fnd_ff;

    // A broken alternation restarts the count, so noise cannot accumulate.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            run_ff  <= 6'h00;
            last_ff <= 1'b0;
            fnd_ff  <= 1'b0;
        end else if (clr) begin
            run_ff  <= 6'h00;
            fnd_ff  <= 1'b0;
        end else if (bit_vld) begin
            last_ff <= bit_in;
            if (bit_in != last_ff) begin
                run_ff <= run_ff + 6'h01;
                if (run_ff + 6'h01 >= 6'(NEED)) fnd_ff <= 1'b1;
            end else begin
                run_ff <= 6'h00;
            end
        end
    end
    assign found = fnd_ff;
endmodule // rad_preamble_corr
`default_nettype wire

// ---- rtl/rad_eval_timer.sv ----
// Down-counting evaluation timer with start, stop and expiry pulse.
`timescale 1ns/1ps
`default_nettype none
module rad_eval_timer #(
    parameter int W = rad_pkg::TMR_W
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic         start,
    input  wire logic         stop,
    input  wire logic [W-1:0] load,
    output logic              running,
    output logic              expire
);
    logic [W-1:0] cnt_ff;
    logic         run_ff;
    logic         exp_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff <= '0;
            run_ff <= 1'b0;
            exp_ff <= 1'b0;
        end else begin
            exp_ff <= 1'b0;
            if (stop) begin
                run_ff <= 1'b0;
            end else if (start) begin
                cnt_ff <= load;
                run_ff <= 1'b1;
            end else if (run_ff) begin
                cnt_ff <= cnt_ff - 1'b1;
                if (cnt_ff <= W'(1)) begin
                    run_ff <= 1'b0;
                    exp_ff <= 1'b1;
                end
            end
        end
    end
    assign running = run_ff;
    assign expire  = exp_ff;
endmodule // rad_eval_timer
`default_nettype wire

// ---- rtl/rad_top.sv ----
// Receive antenna diversity with clear channel assessment and timed evaluation.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rad_top #(
    parameter int CYC_PER_US = rad_pkg::CLK_MHZ,
    parameter int SEARCH_CYC = rad_pkg::SEARCH_CYC_DEF
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [9:0]   reg_addr,
    input  wire logic [7:0]   reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [7:0]   reg_rdata,
    input  wire logic         rx_bit_vld,
    input  wire logic         rx_bit,
    input  wire logic         rssi_vld,
    input  wire logic [7:0]   rssi_val,
    input  wire logic         sfd_det,
    input  wire logic         pkt_end,
    output rad_pkg::rad_state_t radio_state,
    output logic              channel_live_flag,
    output logic              channel_sticky_flag,
    output logic              assess_evt,
    output logic              ant_sel,
    output logic              switch_pin_a_supply,
    output logic              switch_pin_a_supply_oe,
    output logic              switch_pin_b_supply,
    output logic              switch_pin_b_supply_oe,
    output logic              switch_pin_a_low_volt,
    output logic              switch_pin_a_low_volt_oe,
    output logic              switch_pin_b_low_volt,
    output logic              switch_pin_b_low_volt_oe
);

    // ************************************************************
    // Registers and command decode
    // ************************************************************
    logic [7:0] cfg0_ff;
    logic [7:0] thr_ff;
    logic [7:0] div_ff;
    logic [7:0] str0_ff;
    logic [7:0] str1_ff;
    logic [7:0] test_ff;
    logic [7:0] rdata_ff;
    rad_pkg::rad_state_t st_ff;
    logic       ant_ff;
    logic       live_ff;
    logic       stk_ff;
    logic       evt_ff;

    logic cmd_wr;
    logic cmd_rx;
    logic cmd_go;
    logic cmd_on;
    logic div_en;
    logic frz;
    logic in_rx;
    logic meas;
    logic go_ok;
    logic busy;
    logic tmr_run;
    logic tmr_exp;
    logic tmr_stop;
    logic pre_fnd;
    logic corr_clr;
    logic [2:0] per_code;
    logic [rad_pkg::TMR_W-1:0] tmr_load;

    assign cmd_wr   = reg_wr && (reg_addr == rad_pkg::A_CMD);
    assign cmd_rx   = cmd_wr && reg_wdata[rad_pkg::B_C_RX];
    assign cmd_go   = cmd_wr && reg_wdata[rad_pkg::B_C_GO];
    assign cmd_on   = cmd_wr && reg_wdata[rad_pkg::B_C_ON];
    assign div_en   = div_ff[rad_pkg::B_DIVEN];
    assign frz      = cfg0_ff[rad_pkg::B_FRZ];
    assign per_code = cfg0_ff[rad_pkg::B_PER_LO +: 3];
    assign in_rx    = (st_ff == rad_pkg::ST_SRCH) || (st_ff == rad_pkg::ST_PKT)
                   || (st_ff == rad_pkg::ST_RCV);
    assign meas     = in_rx && rssi_vld && !frz;
    // Timed mode needs manual transmit off and a finite period code.
    assign go_ok    = cmd_go && in_rx && !cfg0_ff[rad_pkg::B_MANTX]
                   && (per_code != rad_pkg::PER_INF);
    assign busy     = stk_ff || live_ff;
    assign tmr_load = rad_pkg::TMR_W'(rad_pkg::period_us(per_code) * CYC_PER_US);
    assign tmr_stop = (st_ff == rad_pkg::ST_PKT) && sfd_det;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg0_ff <= rad_pkg::RST8;
            thr_ff  <= rad_pkg::RST8;
            test_ff <= rad_pkg::RST8;
        end else if (reg_wr) begin
            if (reg_addr == rad_pkg::A_CFG0) cfg0_ff <= reg_wdata;
            if (reg_addr == rad_pkg::A_THR) thr_ff <= reg_wdata;
            if (reg_addr == rad_pkg::A_TEST) test_ff <= reg_wdata;
        end
    end

    // Bit 1 is owned by hardware; software writes reach the other bits.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_ff <= rad_pkg::RST8;
        end else begin
            if (reg_wr && reg_addr == rad_pkg::A_DIV) begin
                div_ff <= {reg_wdata[7:2], div_ff[rad_pkg::B_ANT], reg_wdata[0]};
            end
            if (st_ff == rad_pkg::ST_RCV && pkt_end && !test_ff[rad_pkg::B_CONT]) begin
                div_ff[rad_pkg::B_ANT] <= ant_ff;
            end
        end
    end

    // Strength registers keep their value until a fresh measurement or a software write; a
    // measurement in the same cycle as a software write wins.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            str0_ff <= rad_pkg::RST8;
            str1_ff <= rad_pkg::RST8;
        end else begin
            if (meas && !ant_ff) begin
                str0_ff <= rssi_val;
            end else if (reg_wr && reg_addr == rad_pkg::A_STR0) begin
                str0_ff <= reg_wdata;
            end
            if (meas && ant_ff) begin
                str1_ff <= rssi_val;
            end else if (reg_wr && reg_addr == rad_pkg::A_STR1) begin
                str1_ff <= reg_wdata;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_ff <= rad_pkg::RST8;
        end else if (reg_rd) begin
            unique case (reg_addr)
                rad_pkg::A_CFG0: rdata_ff <= cfg0_ff;
                rad_pkg::A_THR:  rdata_ff <= thr_ff;
                rad_pkg::A_DIV:  rdata_ff <= div_ff;
                rad_pkg::A_STR0: rdata_ff <= str0_ff;
                rad_pkg::A_STR1: rdata_ff <= str1_ff;
                rad_pkg::A_TEST: rdata_ff <= test_ff;
                rad_pkg::A_STAT: rdata_ff <= {3'h0, st_ff, stk_ff, live_ff};
                default:         rdata_ff <= rad_pkg::RST8;
            endcase
        end else begin
            rdata_ff <= rad_pkg::RST8;
        end
    end

    // ************************************************************
    // Channel assessment flags
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            live_ff <= 1'b0;
        end else if (meas) begin
            live_ff <= (rssi_val > thr_ff);
        end
    end

    // The start of a period clears; afterwards any busy sample up to its expiry, or a
    // delimiter, sets, and the flag then holds until the next start.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stk_ff <= 1'b0;
        end else if (go_ok) begin
            stk_ff <= 1'b0;
        end else if (((tmr_run || tmr_exp) && live_ff) || tmr_stop) begin
            stk_ff <= 1'b1;
        end
    end

    rad_eval_timer #(
        .W (rad_pkg::TMR_W)
    ) u_tmr (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (go_ok),
        .stop     (tmr_stop),
        .load     (tmr_load),
        .running  (tmr_run),
        .expire   (tmr_exp)
    );

    // ************************************************************
    // Antenna search
    // ************************************************************
    logic [rad_pkg::TMR_W-1:0] srch_ff;
    logic pair_ff;
    logic q_oth_ff;
    logic per_end;

    assign per_end  = (st_ff == rad_pkg::ST_SRCH) && div_en
                   && (srch_ff >= rad_pkg::TMR_W'(SEARCH_CYC - 1));
    assign corr_clr = (st_ff != rad_pkg::ST_SRCH) || per_end;

    rad_preamble_corr #(
        .PAIRS (rad_pkg::PAIRS)
    ) u_corr (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clr      (corr_clr),
        .bit_vld  (rx_bit_vld),
        .bit_in   (rx_bit),
        .found    (pre_fnd)
    );

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            srch_ff <= '0;
        end else if (st_ff != rad_pkg::ST_SRCH || per_end) begin
            srch_ff <= '0;
        end else begin
            srch_ff <= srch_ff + 1'b1;
        end
    end

    // Which antenna won: both qualified picks the stronger, ties go to zero.
    logic pick;
    logic pick_ok;
    always_comb begin
        pick_ok = pair_ff && (pre_fnd || q_oth_ff);
        if (pre_fnd && q_oth_ff) begin
            pick = (str1_ff > str0_ff);
        end else begin
            pick = pre_fnd ? ant_ff : !ant_ff;
        end
    end

    // ************************************************************
    // State machine
    // ************************************************************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_ff    <= rad_pkg::ST_ON;
            ant_ff   <= 1'b0;
            pair_ff  <= 1'b0;
            q_oth_ff <= 1'b0;
        end else if (cmd_on) begin
            st_ff <= rad_pkg::ST_ON;
        end else if (cmd_rx) begin
            st_ff   <= rad_pkg::ST_SRCH;
            ant_ff  <= 1'b0;
            pair_ff <= 1'b0;
        end else begin
            unique case (st_ff)
                rad_pkg::ST_ON: begin
                end
                rad_pkg::ST_SRCH: begin
                    if (tmr_exp && !busy) begin
                        st_ff <= rad_pkg::ST_TX;
                    end else if (!div_en) begin
                        ant_ff <= 1'b0;
                        if (pre_fnd) st_ff <= rad_pkg::ST_PKT;
                    end else if (per_end) begin
                        q_oth_ff <= pre_fnd;
                        pair_ff  <= !pair_ff;
                        if (pick_ok) begin
                            ant_ff  <= pick;
                            pair_ff <= 1'b0;
                            st_ff   <= rad_pkg::ST_PKT;
                        end else begin
                            ant_ff <= !ant_ff;
                        end
                    end
                end
                rad_pkg::ST_PKT: begin
                    if (sfd_det) begin
                        st_ff <= rad_pkg::ST_RCV;
                    end else if (tmr_exp) begin
                        st_ff   <= rad_pkg::ST_SRCH;
                        pair_ff <= 1'b0;
                    end
                end
                rad_pkg::ST_RCV: begin
                    if (pkt_end) begin
                        if (test_ff[rad_pkg::B_CONT]) begin
                            st_ff   <= rad_pkg::ST_SRCH;
                            pair_ff <= 1'b0;
                        end else begin
                            st_ff <= rad_pkg::ST_ON;
                        end
                    end
                end
                rad_pkg::ST_TX: begin
                end
            endcase
        end
    end

    // Event pulse on expiry, or when a delimiter cuts a running period short.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_ff <= 1'b0;
        end else begin
            evt_ff <= tmr_exp || (tmr_stop && tmr_run);
        end
    end

    // ************************************************************
    // Antenna switch pins
    // ************************************************************
    logic [1:0] pat_ff;
    logic       lvl_ff;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pat_ff <= 2'h0;
            lvl_ff <= 1'b0;
        end else begin
            pat_ff <= ant_ff ? div_ff[rad_pkg::B_PAT1 +: 2] : div_ff[rad_pkg::B_PAT0 +: 2];
            lvl_ff <= div_ff[rad_pkg::B_LVL];
        end
    end

    assign switch_pin_a_supply      = pat_ff[1];
    assign switch_pin_b_supply      = pat_ff[0];
    assign switch_pin_a_low_volt    = pat_ff[1];
    assign switch_pin_b_low_volt    = pat_ff[0];
    assign switch_pin_a_supply_oe   = !lvl_ff;
    assign switch_pin_b_supply_oe   = !lvl_ff;
    assign switch_pin_a_low_volt_oe = lvl_ff;
    assign switch_pin_b_low_volt_oe = lvl_ff;

    assign reg_rdata           = rdata_ff;
    assign radio_state         = st_ff;
    assign channel_live_flag   = live_ff;
    assign channel_sticky_flag = stk_ff;
    assign assess_evt          = evt_ff;
    assign ant_sel             = ant_ff;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_LIVE_CMP: assert property (
        meas |=> live_ff == ($past(rssi_val) > $past(thr_ff)))
        else $error("live flag does not follow threshold compare");
    AST_FREEZE: assert property (
        (in_rx && frz && $stable(cfg0_ff)) [*2] |-> $stable(live_ff))
        else $error("live flag moved while frozen");
    AST_OTHER_HELD: assert property (
        (meas && !ant_ff && !reg_wr) |=> $stable(str1_ff))
        else $error("deselected antenna strength changed");
    AST_STICKY_START: assert property (
        go_ok |=> !stk_ff ##1 (stk_ff == $past(live_ff)))
        else $error("sticky flag not cleared then sampled at period start");
    AST_BUSY_STAY: assert property (
        (tmr_exp && busy && st_ff == rad_pkg::ST_SRCH && !cmd_wr)
        |=> st_ff == rad_pkg::ST_SRCH && stk_ff && assess_evt)
        else $error("busy expiry did not stay with event");
    AST_CLEAR_TX: assert property (
        (tmr_exp && !busy && st_ff == rad_pkg::ST_SRCH && !cmd_wr) |=> st_ff == rad_pkg::ST_TX)
        else $error("clear expiry did not enter transmit");
    AST_SFD: assert property (
        (tmr_stop && tmr_run && !cmd_wr)
        |=> st_ff == rad_pkg::ST_RCV && stk_ff && assess_evt && !tmr_run)
        else $error("delimiter handling wrong");
    AST_DROP: assert property (
        (st_ff == rad_pkg::ST_PKT && tmr_exp && !sfd_det && !cmd_wr) |=> st_ff == rad_pkg::ST_SRCH)
        else $error("expiry during preamble did not drop packet");
    AST_CONT: assert property (
        (st_ff == rad_pkg::ST_RCV && pkt_end && test_ff[rad_pkg::B_CONT] && !cmd_wr)
        |=> st_ff == rad_pkg::ST_SRCH)
        else $error("continuous receive did not return to search");
    AST_PINS: assert property (
        $stable(div_ff) [*2] |-> switch_pin_a_low_volt_oe == div_ff[rad_pkg::B_LVL]
        && switch_pin_a_supply_oe != div_ff[rad_pkg::B_LVL])
        else $error("pin pair selection wrong");

endmodule // rad_top
`default_nettype wire

// ---- verification/rad_partner.sv ----
// Antenna switch and baseband stand-in: resolves switch pins to a path and feeds strength samples and bits.
`timescale 1ns/1ps
`default_nettype none
module rad_partner #(
    parameter logic [1:0] PATH1 = 2'h1
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] pin,
    input  wire logic [3:0] oe,
    input  wire logic       pre_on,
    input  wire logic [7:0] lvl0,
    input  wire logic [7:0] lvl1,
    output logic      [1:0] path,
    output logic            rssi_vld,
    output logic      [7:0] rssi_val,
    output logic            rx_bit_vld,
    output logic            rx_bit
);
    logic tog_ff;

    // An undriven pair has no pull, so it shows a level that changes every cycle.
    assign path[1] = oe[3] ? pin[3] : (oe[1] ? pin[1] : tog_ff);
    assign path[0] = oe[2] ? pin[2] : (oe[0] ? pin[0] : ~tog_ff);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tog_ff     <= 1'b0;
            rssi_vld   <= 1'b0;
            rssi_val   <= 8'h00;
            rx_bit_vld <= 1'b0;
            rx_bit     <= 1'b0;
        end else begin
            tog_ff     <= ~tog_ff;
            rssi_vld   <= tog_ff;
            rssi_val   <= (path == PATH1) ? lvl1 : lvl0;
            rx_bit_vld <= pre_on;
            rx_bit     <= pre_on ? ~rx_bit : 1'b0;
        end
    end
endmodule // rad_partner
`default_nettype wire

// ---- verification/rad_top_bench.sv ----
// Self-checking testbench of the antenna diversity and channel assessment block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module rad_top_bench;
    logic       core_clk  = 1'b0;
    logic       rst_n     = 1'b0;
    logic [9:0] reg_addr  = 10'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_wr    = 1'b0;
    logic       reg_rd    = 1'b0;
    logic       sfd_det   = 1'b0;
    logic       pkt_end   = 1'b0;
    logic       pre_on    = 1'b0;
    logic [7:0] lvl0      = 8'h00;
    logic [7:0] lvl1      = 8'h00;
    logic [7:0] reg_rdata, rssi_val, d;
    logic       rx_bit_vld, rx_bit, rssi_vld, live, sticky, evt, ant_sel;
    logic [3:0] pin, oe;
    logic [1:0] path;
    rad_pkg::rad_state_t st;
    int         n_mismatch = 0;
    int         checked    = 0;
    int         n;

    rad_top #(.CYC_PER_US(1), .SEARCH_CYC(50)) dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_bit_vld(rx_bit_vld),
        .rx_bit(rx_bit), .rssi_vld(rssi_vld), .rssi_val(rssi_val), .sfd_det(sfd_det),
        .pkt_end(pkt_end), .radio_state(st), .channel_live_flag(live), .channel_sticky_flag(sticky),
        .assess_evt(evt), .ant_sel(ant_sel),
        .switch_pin_a_supply(pin[3]), .switch_pin_a_supply_oe(oe[3]),
        .switch_pin_b_supply(pin[2]), .switch_pin_b_supply_oe(oe[2]),
        .switch_pin_a_low_volt(pin[1]), .switch_pin_a_low_volt_oe(oe[1]),
        .switch_pin_b_low_volt(pin[0]), .switch_pin_b_low_volt_oe(oe[0]));

    rad_partner partner_u (
        .core_clk(core_clk), .rst_n(rst_n), .pin(pin), .oe(oe), .pre_on(pre_on), .lvl0(lvl0),
        .lvl1(lvl1), .path(path), .rssi_vld(rssi_vld), .rssi_val(rssi_val),
        .rx_bit_vld(rx_bit_vld), .rx_bit(rx_bit));

    always #2 core_clk = ~core_clk;

    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask

    // Bounded wait on the design's own event pulse; n keeps the cycles taken.
    task automatic wait_evt();
        n = 0;
        while (evt !== 1'b1 && n < 12000) begin
            cyc(1);
            n++;
        end
    endtask

    task automatic t_regs();
        rd(rad_pkg::A_THR);
        `CHK(d, 8'h00)
        wr(rad_pkg::A_STR0, 8'h5a);
        wr(rad_pkg::A_STR1, 8'ha5);
        rd(rad_pkg::A_STR0);
        `CHK(d, 8'h5a)
        rd(rad_pkg::A_STR1);
        `CHK(d, 8'ha5)
        wr(rad_pkg::A_DIV, 8'h02);
        rd(rad_pkg::A_DIV);
        `CHK(d, 8'h00)
        rd(10'h3ff);
        `CHK(d, 8'h00)
    endtask

    task automatic t_pins();
        for (int k = 0; k < 8; k++) begin
            wr(rad_pkg::A_DIV, {k[1:0], 2'h1, k[2], 3'h0});
            cyc(2);
            `CHK(path, k[1:0])
            `CHK(oe, k[2] ? 4'h3 : 4'hc)
        end
    endtask

    task automatic t_clear();
        lvl0 <= 8'h30;
        wr(rad_pkg::A_THR, 8'hff);
        wr(rad_pkg::A_CFG0, 8'h00);
        wr(rad_pkg::A_CMD, 8'h01);
        wr(rad_pkg::A_CMD, 8'h02);
        wait_evt();
        `CHK(n >= 160 && n <= 164, 1'b1)
        `CHK(st, rad_pkg::ST_TX)
        `CHK(sticky, 1'b0)
        wr(rad_pkg::A_CMD, 8'h04);
        cyc(2);
        `CHK(st, rad_pkg::ST_ON)
    endtask

    task automatic t_busy();
        wr(rad_pkg::A_THR, 8'h10);
        wr(rad_pkg::A_CFG0, 8'h02);
        wr(rad_pkg::A_CMD, 8'h01);
        cyc(6);
        `CHK(live, 1'b1)
        wr(rad_pkg::A_CMD, 8'h02);
        wait_evt();
        `CHK(n >= 320 && n <= 324, 1'b1)
        `CHK(st, rad_pkg::ST_SRCH)
        `CHK(sticky, 1'b1)
        wr(rad_pkg::A_CFG0, 8'h03);
        lvl0 <= 8'h00;
        cyc(8);
        `CHK(live, 1'b1)
        wr(rad_pkg::A_CFG0, 8'h02);
        cyc(8);
        `CHK(live, 1'b0)
        wr(rad_pkg::A_CMD, 8'h02);
        cyc(20);
        lvl0 <= 8'h40;
        cyc(6);
        lvl0 <= 8'h00;
        wait_evt();
        `CHK(sticky, 1'b1)
        wr(rad_pkg::A_CMD, 8'h04);
    endtask

    // A timed period that runs out while a preamble is pending drops the packet.
    task automatic t_drop();
        pre_on <= 1'b1;
        wr(rad_pkg::A_CMD, 8'h01);
        cyc(30);
        `CHK(st, rad_pkg::ST_PKT)
        wr(rad_pkg::A_CFG0, 8'h1c);
        wr(rad_pkg::A_CMD, 8'h02);
        cyc(1);
        `CHK(sticky, 1'b1)
        wr(rad_pkg::A_CFG0, 8'h0c);
        wr(rad_pkg::A_CMD, 8'h02);
        wait_evt();
        `CHK(n >= 9960 && n <= 9964, 1'b1)
        `CHK(st, rad_pkg::ST_SRCH)
        `CHK(sticky, 1'b0)
        pre_on <= 1'b0;
        wr(rad_pkg::A_CMD, 8'h04);
    endtask

    // Both antennas carry preamble; antenna one is stronger and must win the search.
    task automatic t_div(input logic cont);
        wr(rad_pkg::A_THR, 8'hff);
        wr(rad_pkg::A_TEST, {7'h00, cont});
        wr(rad_pkg::A_DIV, 8'h91);
        lvl0   <= 8'h30;
        lvl1   <= 8'h60;
        pre_on <= 1'b1;
        wr(rad_pkg::A_CMD, 8'h01);
        n = 0;
        while (st !== rad_pkg::ST_PKT && n < 400) begin
            cyc(1);
            n++;
        end
        `CHK(n >= 100, 1'b1)
        `CHK(ant_sel, 1'b1)
        `CHK(path, 2'h1)
        rd(rad_pkg::A_STR0);
        `CHK(d, 8'h30)
        wr(rad_pkg::A_CMD, 8'h02);
        @(posedge core_clk);
        pre_on  <= 1'b0;
        sfd_det <= 1'b1;
        @(posedge core_clk);
        sfd_det <= 1'b0;
        #1;
        `CHK(evt, 1'b1)
        `CHK(st, rad_pkg::ST_RCV)
        `CHK(sticky, 1'b1)
        @(posedge core_clk);
        pkt_end <= 1'b1;
        @(posedge core_clk);
        pkt_end <= 1'b0;
        cyc(1);
        `CHK(st, cont ? rad_pkg::ST_SRCH : rad_pkg::ST_ON)
        rd(rad_pkg::A_DIV);
        `CHK(d, 8'h93)
        wr(rad_pkg::A_CMD, 8'h04);
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_pins();
        t_clear();
        t_busy();
        t_drop();
        t_div(1'b0);
        t_div(1'b1);
        close_out();
    end

    // Whole run is about twelve thousand cycles; this limit allows twice that.
    initial begin
        #100000;
        n_mismatch++;
        close_out();
    end
endmodule // rad_top_bench
`default_nettype wire
